// ===== core/atc_pkg.sv
// Package with register map, field layout and timing tables of the AGC block.
package atc_pkg;

  // Register offsets on the codec control port.
  localparam logic [6:0] ATC_OFF_LEFT_ATTACK  = 7'h67;
  localparam logic [6:0] ATC_OFF_LEFT_DECAY   = 7'h68;
  localparam logic [6:0] ATC_OFF_RIGHT_ATTACK = 7'h69;

  // Field layout shared by all three timing registers.
  localparam int ATC_SEL_BIT  = 7;
  localparam int ATC_BASE_HI  = 6;
  localparam int ATC_BASE_LO  = 5;
  localparam int ATC_MULT_HI  = 4;
  localparam int ATC_MULT_LO  = 2;

  // Register reset value and the read answer for unmapped offsets.
  localparam logic [7:0] ATC_REG_RESET = 8'h00;
  localparam logic [7:0] ATC_RD_NONE   = 8'h00;

  // Baseline attack times in milliseconds, codes 0 to 3.
  localparam logic [15:0] ATC_ATK_BASE0_MS = 16'h0007;
  localparam logic [15:0] ATC_ATK_BASE1_MS = 16'h0008;
  localparam logic [15:0] ATC_ATK_BASE2_MS = 16'h000a;
  localparam logic [15:0] ATC_ATK_BASE3_MS = 16'h000b;

  // Baseline decay times in milliseconds, codes 0 to 3.
  localparam logic [15:0] ATC_DEC_BASE0_MS = 16'h0032;
  localparam logic [15:0] ATC_DEC_BASE1_MS = 16'h0096;
  localparam logic [15:0] ATC_DEC_BASE2_MS = 16'h00fa;
  localparam logic [15:0] ATC_DEC_BASE3_MS = 16'h015e;

  // Decimation ratio is carried as twice its value, so 1.5 becomes 3.
  localparam logic [3:0] ATC_RATIO_1   = 4'h2;
  localparam logic [3:0] ATC_RATIO_1P5 = 4'h3;
  localparam logic [3:0] ATC_RATIO_2   = 4'h4;
  localparam logic [3:0] ATC_RATIO_2P5 = 4'h5;
  localparam logic [3:0] ATC_RATIO_3   = 4'h6;
  localparam logic [3:0] ATC_RATIO_3P5 = 4'h7;
  localparam logic [3:0] ATC_RATIO_4   = 4'h8;
  localparam logic [3:0] ATC_RATIO_4P5 = 4'h9;
  localparam logic [3:0] ATC_RATIO_5   = 4'ha;

  // Longest decay in milliseconds for each decimation ratio.
  localparam logic [15:0] ATC_CAP_R1_MS   = 16'h0fa0;
  localparam logic [15:0] ATC_CAP_R1P5_MS = 16'h15e0;
  localparam logic [15:0] ATC_CAP_R2_MS   = 16'h1f40;
  localparam logic [15:0] ATC_CAP_R2P5_MS = 16'h2580;
  localparam logic [15:0] ATC_CAP_R3_MS   = 16'h2bc0;
  localparam logic [15:0] ATC_CAP_R4_MS   = 16'h3e80;
  localparam logic [15:0] ATC_CAP_R5_MS   = 16'h4b00;
  localparam logic [15:0] ATC_CAP_R6_MS   = 16'h5780;

endpackage : atc_pkg

// ===== core/atc_time_scale.sv
// Baseline lookup and power-of-two scaling for one AGC time constant.
`timescale 1ns/10ps
module atc_time_scale #(
  parameter bit IS_DECAY = 1'b0
) (
  // Fields of one timing register.
  input  wire logic [1:0]  base_code,
  input  wire logic [2:0]  mult_code,
  // Baseline times the factor, in milliseconds.
  output logic      [15:0] time_ms
);
  import atc_pkg::*;

  logic [15:0] base_ms;

  // Attack and decay share the scaler and differ only in their baselines.
  always_comb begin
    case (base_code)
      2'h0:    base_ms = IS_DECAY ? ATC_DEC_BASE0_MS : ATC_ATK_BASE0_MS;
      2'h1:    base_ms = IS_DECAY ? ATC_DEC_BASE1_MS : ATC_ATK_BASE1_MS;
      2'h2:    base_ms = IS_DECAY ? ATC_DEC_BASE2_MS : ATC_ATK_BASE2_MS;
      default: base_ms = IS_DECAY ? ATC_DEC_BASE3_MS : ATC_ATK_BASE3_MS;
    endcase
  end

  // The largest product, 350 ms times 128, still fits in 16 bits.
  assign time_ms = base_ms << mult_code;

endmodule : atc_time_scale

// ===== core/atc_time_config.sv
// Register bank choosing legacy or scaled AGC attack and decay times.
`timescale 1ns/10ps
// What this block does
// RULE1 - Left attack baseline code picks 7, 8, 10 or 11 ms.
// RULE2 - Attack multiplier code scales baseline by two to the code.
// RULE3 - Software writes zeros to the two reserved low bits.
// RULE4 - Left decay top bit picks legacy timing or new decay fields.
// RULE5 - Left decay baseline code picks 50, 150, 250 or 350 ms.
// RULE6 - Decay multiplier code scales baseline by two to the code.
// RULE7 - Effective decay is capped by the ADC decimation ratio.
// RULE8 - Right attack top bit picks legacy timing or new attack fields.
// RULE9 - Right attack baseline code picks 7, 8, 10 or 11 ms.
// RULE10 - All new timing registers reset to zero.
// RULE11 - Left attack top bit picks legacy timing or new attack fields.
// RULE12 - New source gives baseline times power-of-two factor.
// RULE13 - Under legacy source the fields are stored but have no effect.
module atc_time_config (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Codec control port.
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_q,
  // Legacy times and decimation ratio from neighbouring logic.
  input  wire logic [15:0] legacy_left_attack_ms,
  input  wire logic [15:0] legacy_left_decay_ms,
  input  wire logic [15:0] legacy_right_attack_ms,
  input  wire logic [3:0]  adc_decimation_ratio,
  // Effective time constants for the AGC loop.
  output logic      [15:0] left_attack_ms_q,
  output logic      [15:0] left_decay_ms_q,
  output logic      [15:0] right_attack_ms_q
);
  import atc_pkg::*;

  logic [7:0]  left_attack_q;
  logic [7:0]  left_decay_q;
  logic [7:0]  right_attack_q;
  logic [15:0] la_new_ms;
  logic [15:0] ld_new_ms;
  logic [15:0] ra_new_ms;
  logic [15:0] ld_raw_ms;
  logic [15:0] decay_cap_ms;

  // Longest decay allowed at a given ratio; codes past 10 take the top cap.
  function automatic logic [15:0] decay_cap(input logic [3:0] ratio);
    if (ratio <= ATC_RATIO_1) begin
      decay_cap = ATC_CAP_R1_MS;
    end else if (ratio == ATC_RATIO_1P5) begin
      decay_cap = ATC_CAP_R1P5_MS;
    end else if (ratio == ATC_RATIO_2) begin
      decay_cap = ATC_CAP_R2_MS;
    end else if (ratio == ATC_RATIO_2P5) begin
      decay_cap = ATC_CAP_R2P5_MS;
    end else if (ratio == ATC_RATIO_3 || ratio == ATC_RATIO_3P5) begin
      decay_cap = ATC_CAP_R3_MS;
    end else if (ratio == ATC_RATIO_4 || ratio == ATC_RATIO_4P5) begin
      decay_cap = ATC_CAP_R4_MS;
    end else if (ratio == ATC_RATIO_5) begin
      decay_cap = ATC_CAP_R5_MS;
    end else begin
      decay_cap = ATC_CAP_R6_MS;
    end
  endfunction : decay_cap

  // RULE10 zero on reset.
  // Reserved low bits are kept as written so software reads back its value;
  // RULE3 software keeps them zero, and nothing here reads them.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      left_attack_q  <= ATC_REG_RESET;
      left_decay_q   <= ATC_REG_RESET;
      right_attack_q <= ATC_REG_RESET;
    end else if (reg_wr_en) begin
      if (reg_addr == ATC_OFF_LEFT_ATTACK) begin
        left_attack_q <= reg_wdata;
      end else if (reg_addr == ATC_OFF_LEFT_DECAY) begin
        left_decay_q <= reg_wdata;
      end else if (reg_addr == ATC_OFF_RIGHT_ATTACK) begin
        right_attack_q <= reg_wdata;
      end
    end
  end

  // Read data is registered; unmapped offsets answer zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= ATC_RD_NONE;
    end else if (reg_rd_en) begin
      if (reg_addr == ATC_OFF_LEFT_ATTACK) begin
        reg_rdata_q <= left_attack_q;
      end else if (reg_addr == ATC_OFF_LEFT_DECAY) begin
        reg_rdata_q <= left_decay_q;
      end else if (reg_addr == ATC_OFF_RIGHT_ATTACK) begin
        reg_rdata_q <= right_attack_q;
      end else begin
        reg_rdata_q <= ATC_RD_NONE;
      end
    end
  end

  // RULE1 RULE2 left attack scaling.
  atc_time_scale #(.IS_DECAY(1'b0)) u_left_attack (
    .base_code (left_attack_q[ATC_BASE_HI:ATC_BASE_LO]),
    .mult_code (left_attack_q[ATC_MULT_HI:ATC_MULT_LO]),
    .time_ms   (la_new_ms)
  );

  // RULE5 RULE6 left decay scaling.
  atc_time_scale #(.IS_DECAY(1'b1)) u_left_decay (
    .base_code (left_decay_q[ATC_BASE_HI:ATC_BASE_LO]),
    .mult_code (left_decay_q[ATC_MULT_HI:ATC_MULT_LO]),
    .time_ms   (ld_new_ms)
  );

  // RULE9 RULE2 right attack scaling.
  atc_time_scale #(.IS_DECAY(1'b0)) u_right_attack (
    .base_code (right_attack_q[ATC_BASE_HI:ATC_BASE_LO]),
    .mult_code (right_attack_q[ATC_MULT_HI:ATC_MULT_LO]),
    .time_ms   (ra_new_ms)
  );

  // RULE4 decay source select, capped afterwards by the ratio.
  assign ld_raw_ms    = left_decay_q[ATC_SEL_BIT] ? ld_new_ms
                                                  : legacy_left_decay_ms;
  assign decay_cap_ms = decay_cap(adc_decimation_ratio);

  // RULE11 RULE12 RULE13 left attack source select.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      left_attack_ms_q <= '0;
    end else begin
      left_attack_ms_q <= left_attack_q[ATC_SEL_BIT] ? la_new_ms
                                                     : legacy_left_attack_ms;
    end
  end

  // RULE7 decay cap. The cap covers the legacy source too, since the
  // decimator limits the loop whichever register set the time.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      left_decay_ms_q <= '0;
    end else begin
      left_decay_ms_q <= (ld_raw_ms > decay_cap_ms) ? decay_cap_ms
                                                    : ld_raw_ms;
    end
  end

  // RULE8 RULE12 right attack source select.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      right_attack_ms_q <= '0;
    end else begin
      right_attack_ms_q <= right_attack_q[ATC_SEL_BIT] ? ra_new_ms
                                                       : legacy_right_attack_ms;
    end
  end

  // Checks on the register bank and the time selection.
  // RULE10 reset clears registers.
  reset_clear_a: assert property (@(posedge clk_sys) // RULE10
    rst |=> (left_attack_q == ATC_REG_RESET && left_decay_q == ATC_REG_RESET
             && right_attack_q == ATC_REG_RESET && left_attack_ms_q == '0))
    else $error("Timing registers not cleared by reset.");

  // RULE1 top baseline code, here at the top multiplier.
  la_base_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    (left_attack_q[ATC_SEL_BIT:ATC_MULT_LO] == 6'h3f)
    |=> left_attack_ms_q == (ATC_ATK_BASE3_MS << 7))
    else $error("Left attack baseline code wrong.");

  // RULE2 top multiplier code.
  la_mult_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    (left_attack_q[ATC_SEL_BIT:ATC_MULT_LO] == 6'h37)
    |=> left_attack_ms_q == (ATC_ATK_BASE2_MS << 7))
    else $error("Left attack multiplier wrong.");

  // RULE11 RULE13 legacy attack source.
  la_legacy_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
    !left_attack_q[ATC_SEL_BIT]
    |=> left_attack_ms_q == $past(legacy_left_attack_ms))
    else $error("Left attack not from legacy source.");

  // RULE4 legacy decay below the cap.
  ld_legacy_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
    (!left_decay_q[ATC_SEL_BIT] && legacy_left_decay_ms <= ATC_CAP_R1_MS)
    |=> left_decay_ms_q == $past(legacy_left_decay_ms))
    else $error("Left decay not from legacy source.");

  // RULE5 RULE6 decay scaling below the cap.
  // The product, 1200 ms, lies under the smallest cap, so no ratio clips it.
  ld_scale_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
    (left_decay_q[ATC_SEL_BIT:ATC_MULT_LO] == 6'h2b)
    |=> left_decay_ms_q == (ATC_DEC_BASE1_MS << 3))
    else $error("Left decay scaling wrong.");

  // RULE7 decay held at the cap one edge later.
  ld_cap_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
    (left_decay_q == 8'hfc && adc_decimation_ratio == ATC_RATIO_2)
    |=> left_decay_ms_q == ATC_CAP_R2_MS)
    else $error("Left decay cap not applied.");

  // RULE8 RULE9 right attack source and baseline.
  ra_select_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
    right_attack_q[ATC_SEL_BIT]
    |=> right_attack_ms_q ==
        ((($past(right_attack_q[ATC_BASE_HI:ATC_BASE_LO]) == 2'h0)
          ? ATC_ATK_BASE0_MS
          : ($past(right_attack_q[ATC_BASE_HI:ATC_BASE_LO]) == 2'h1)
          ? ATC_ATK_BASE1_MS
          : ($past(right_attack_q[ATC_BASE_HI:ATC_BASE_LO]) == 2'h2)
          ? ATC_ATK_BASE2_MS : ATC_ATK_BASE3_MS)
         << $past(right_attack_q[ATC_MULT_HI:ATC_MULT_LO])))
    else $error("Right attack time wrong.");

  // Register write reaches the read port two edges later.
  wr_rd_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
    (reg_wr_en && reg_addr == ATC_OFF_LEFT_ATTACK)
    ##1 (reg_rd_en && reg_addr == ATC_OFF_LEFT_ATTACK && !reg_wr_en)
    |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("Stored field not read back.");

endmodule : atc_time_config

// ===== sim/atc_tb.sv
// Self-checking testbench for the AGC time constant register bank.
`timescale 1ns/10ps
module testbench;
  import atc_pkg::*;

  typedef struct packed {
    logic [6:0]  a;
    logic [7:0]  d;
    logic [15:0] e;
  } atc_row_t;

  // Each row writes one register and names the time that it should give.
  localparam atc_row_t ROWS [0:14] = '{
    '{7'h67, 8'h80, 16'h0007}, '{7'h67, 8'ha4, 16'h0010},
    '{7'h67, 8'hdc, 16'h0500}, '{7'h67, 8'hfc, 16'h0580},
    '{7'h67, 8'h7c, 16'h0123}, '{7'h68, 8'h80, 16'h0032},
    '{7'h68, 8'hac, 16'h04b0}, '{7'h68, 8'hdc, 16'h5780},
    '{7'h68, 8'hec, 16'h0af0}, '{7'h68, 8'h00, 16'h0456},
    '{7'h69, 8'h80, 16'h0007}, '{7'h69, 8'hb0, 16'h0080},
    '{7'h69, 8'hd4, 16'h0140}, '{7'h69, 8'hf8, 16'h02c0},
    '{7'h69, 8'h00, 16'h0789}};
  // Longest decay for ratio codes 2 up to 12.
  localparam logic [15:0] CAPS [0:10] = '{16'h0fa0, 16'h15e0, 16'h1f40,
    16'h2580, 16'h2bc0, 16'h2bc0, 16'h3e80, 16'h3e80, 16'h4b00, 16'h5780,
    16'h5780};

  // Stimulus and observed signals.
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [6:0]  reg_addr  = 7'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [3:0]  ratio     = 4'hc;
  logic [7:0]  reg_rdata_q;
  logic [15:0] la_q;
  logic [15:0] ld_q;
  logic [15:0] ra_q;
  int          err_count = 0;
  int          checked   = 0;

  // The clock toggles every 12.5 ns, so one period is 25 ns.
  always #12.5 clk_sys = ~clk_sys;

  atc_time_config u_dut (
    .clk_sys                (clk_sys),
    .rst                    (rst),
    .reg_wr_en              (reg_wr_en),
    .reg_rd_en              (reg_rd_en),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_rdata_q            (reg_rdata_q),
    .legacy_left_attack_ms  (16'h0123),
    .legacy_left_decay_ms   (16'h0456),
    .legacy_right_attack_ms (16'h0789),
    .adc_decimation_ratio   (ratio),
    .left_attack_ms_q       (la_q),
    .left_decay_ms_q        (ld_q),
    .right_attack_ms_q      (ra_q)
  );

  // Prints the totals and the verdict, then stops the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One request per edge; inputs change 2 ns after the edge.
  task automatic drive(input logic we, input logic re, input logic [6:0] a,
                       input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    reg_wr_en = we;
    reg_rd_en = re;
    reg_addr  = a;
    reg_wdata = d;
  endtask : drive

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    drive(1'b0, 1'b1, a, 8'h00);
    drive(1'b0, 1'b0, a, 8'h00);
    chk({8'h00, reg_rdata_q}, {8'h00, exp});
  endtask : rd

  // Outputs follow a register update one edge later; two edges are waited.
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #2;
  endtask : settle

  function automatic logic [15:0] out_of(input logic [6:0] a);
    return (a == 7'h67) ? la_q : (a == 7'h68) ? ld_q : ra_q;
  endfunction : out_of

  // Cuts a hang short well after the expected run length.
  initial begin
    #(25 * 4000);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #2;
    chk(la_q | ld_q | ra_q, 16'h0000);
    rst = 1'b0;
    settle();
    for (int i = 0; i < 3; i++) begin
      rd(ATC_OFF_LEFT_ATTACK + 7'(i), 8'h00);
    end
    chk(la_q, 16'h0123);
    chk(ld_q, 16'h0456);
    chk(ra_q, 16'h0789);
    // Table rows: write with zero reserved bits, check time, read back.
    foreach (ROWS[i]) begin
      drive(1'b1, 1'b0, ROWS[i].a, ROWS[i].d);
      drive(1'b0, 1'b0, 7'h00, 8'h00);
      settle();
      chk(out_of(ROWS[i].a), ROWS[i].e);
      rd(ROWS[i].a, ROWS[i].d);
    end
    // Largest decay against every decimation ratio.
    drive(1'b1, 1'b0, ATC_OFF_LEFT_DECAY, 8'hfc);
    for (int i = 0; i < 11; i++) begin
      drive(1'b0, 1'b0, 7'h00, 8'h00);
      ratio = 4'(i + 2);
      settle();
      chk(ld_q, CAPS[i]);
    end
    // Back-to-back writes, read and write in one cycle, then a read behind.
    drive(1'b1, 1'b0, ATC_OFF_LEFT_ATTACK, 8'h84);
    drive(1'b1, 1'b0, ATC_OFF_RIGHT_ATTACK, 8'hac);
    drive(1'b1, 1'b1, ATC_OFF_LEFT_ATTACK, 8'hd8);
    drive(1'b0, 1'b1, ATC_OFF_LEFT_ATTACK, 8'h00);
    chk({8'h00, reg_rdata_q}, 16'h0084);
    settle();
    chk({8'h00, reg_rdata_q}, 16'h00d8);
    chk(la_q, 16'h0280);
    chk(ra_q, 16'h0040);
    // Unmapped offsets ignore writes and read as zero.
    drive(1'b1, 1'b0, 7'h6a, 8'hff);
    rd(7'h6a, 8'h00);
    rd(7'h66, 8'h00);
    // A reset in mid-run clears the bank back to legacy timing.
    drive(1'b0, 1'b0, 7'h00, 8'h00);
    rst = 1'b1;
    settle();
    chk(la_q | ld_q | ra_q, 16'h0000);
    rst = 1'b0;
    settle();
    rd(ATC_OFF_LEFT_ATTACK, 8'h00);
    rd(ATC_OFF_LEFT_DECAY, 8'h00);
    chk(la_q, 16'h0123);
    chk(ld_q, 16'h0456);
    chk(ra_q, 16'h0789);
    complete_run();
  end
endmodule : testbench
